// ---- rtl/adc_ctrl_pkg.sv ----
// Constants shared by the converter control block and its sequencer.
// Assumes a 32-bit classic Wishbone bus with byte addressing.
package adc_ctrl_pkg;

  localparam int          ADDR_W               = 8;
  localparam int          DATA_W               = 32;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  ADC_STATUS_CONTROL_IDX = 8'h38;
  localparam logic [7:0]  ADC_RESULT_IDX         = 8'h39;
  localparam logic [7:0]  ADC_CLOCK_SELECT_IDX   = 8'h3A;

  // Status and control fields
  localparam int          DONE_FLAG_BIT        = 7;
  localparam int          IRQ_EN_BIT           = 6;
  localparam int          CONT_BIT             = 5;
  localparam int          CHAN_LSB             = 0;
  localparam int          CHAN_W               = 5;

  // Clock select fields
  localparam int          PRESCALE_LSB         = 5;
  localparam int          PRESCALE_W           = 3;
  localparam int          SRC_BIT              = 4;

  // Reset values
  localparam logic [4:0]  CHAN_RESET           = 5'h1F;
  localparam logic [2:0]  PRESCALE_RESET       = 3'h0;
  localparam logic        SRC_RESET            = 1'b0;

  // Channel codes
  localparam logic [4:0]  CHAN_PORT_B_LAST     = 5'h07;
  localparam logic [4:0]  CHAN_PORT_D_FIRST    = 5'h08;
  localparam logic [4:0]  CHAN_PORT_D_LAST     = 5'h0E;
  localparam logic [4:0]  CHAN_REF_HIGH        = 5'h1D;
  localparam logic [4:0]  CHAN_REF_LOW         = 5'h1E;
  localparam logic [4:0]  CHAN_POWER_OFF       = 5'h1F;

  // One conversion spans this many conversion clocks
  localparam int          CONV_CLOCKS          = 16;
  localparam logic [3:0]  CONV_LAST_STEP       = 4'hF;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARMED,
    ST_CONVERT
  } conv_state_e;

endpackage

// ---- rtl/adc_sar_core.sv ----
// Successive-approximation sequencer: one trial bit per two conversion clocks.
// Assumes conv_tick is a one-cycle pulse and comparator is already synchronised.
// Each conversion clock should span three or more bus clocks, or the comparator lags the trial.
`timescale 1ns/1ps
`default_nettype none
module adc_sar_core (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       conv_tick,
  input  wire logic       begin_conv,
  input  wire logic       abort,
  input  wire logic       comparator,
  output logic            busy,
  output logic            done,
  output logic [7:0]      result,
  output logic [7:0]      trial_code
);
  import adc_ctrl_pkg::*;

  typedef struct packed {
    logic       busy;
    logic       done;
    logic [3:0] step;
    logic [7:0] trial;
    logic [7:0] result;
  } sar_s;

  sar_s r, r_nxt;

  always_comb begin
    logic [2:0] idx;
    logic [7:0] mask;
    logic [7:0] kept;
    idx   = 3'd7 - r.step[3:1];
    mask  = 8'h01 << idx;
    kept  = comparator ? r.trial : (r.trial & ~mask);
    r_nxt = r;
    r_nxt.done = 1'b0;
    if (rst) begin
      r_nxt.busy  = 1'b0;
      r_nxt.step  = 4'h0;
      r_nxt.trial = 8'h00;
    end else if (abort) begin
      r_nxt.busy  = 1'b0;
      r_nxt.step  = 4'h0;
    end else if (begin_conv) begin
      // The starting tick is the first of the sixteen
      r_nxt.busy  = 1'b1;
      r_nxt.step  = 4'h1;
      r_nxt.trial = 8'h80;
    end else if (r.busy && conv_tick) begin
      r_nxt.step = r.step + 4'h1;
      if (r.step[0]) begin
        if (idx == 3'd0) begin
          r_nxt.result = kept;
          r_nxt.done   = 1'b1;
          r_nxt.busy   = 1'b0;
          r_nxt.trial  = kept;
        end else begin
          r_nxt.trial = kept | (mask >> 1);
        end
      end
    end
  end

  // Result is left out of reset on purpose
  always_ff @(posedge clk) begin
    if (rst || ce) begin
      r <= r_nxt;
    end
  end

  assign busy       = r.busy;
  assign done       = r.done;
  assign result     = r.result;
  assign trial_code = r.trial;

  a_done_last_step : assert property (
    @(posedge clk) disable iff (rst)
    (ce && r.busy && conv_tick && !abort && !begin_conv && r.step == CONV_LAST_STEP)
    |=> done)
    else $error("conversion did not end on its sixteenth clock");

  a_abort_stops : assert property (
    @(posedge clk) disable iff (rst)
    (ce && abort) |=> (!busy && !done))
    else $error("abort left the sequencer running");

endmodule // adc_sar_core
`default_nettype wire

// ---- rtl/adc_control_registers.sv ----
// Control, clocking and register file of an 8-bit successive-approximation converter.
// Assumes a classic Wishbone master on clk; oscillator and comparator come from pins.
// Behaviour
// - With interrupts disabled, done flag bit 7 sets on each finished conversion.
// - Status write, result read or reset clears the done flag.
// - With interrupts enabled the done flag never sets.
// - Enable bit 6 raises interrupt per conversion; result read or status write drops it.
// - Continuous bit 5 repeats conversions; cleared means one conversion only.
// - Reset loads channel ones, clears flag, interrupt enable and continuous.
// - Channel codes 0-7 select port B inputs, 8-14 port D inputs.
// - Codes 0F-1A and 1C unused with unknown result; 1B reserved.
// - Codes 1D and 1E route high and low reference nodes.
// - All-ones channel code powers the converter off.
// - Read-only 8-bit result rewritten per conversion, kept through reset.
// - Conversion clock comes from selected source through 3-bit prescaler.
// - Prescaler divides by 1, 2, 4, 8, or 16 when top bit set.
// - Source bit 4 picks bus clock when one, oscillator when zero.
// - A conversion takes sixteen clocks, starting on first tick after status write.
// - Continuous mode overwrites the previous result, read or not.
// - Stop mode aborts a conversion; converting resumes after stop ends.
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module adc_control_registers (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         ce,
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [adc_ctrl_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [adc_ctrl_pkg::DATA_W-1:0] wb_dat_i,
  output logic [adc_ctrl_pkg::DATA_W-1:0]   wb_dat_o,
  output logic                              wb_ack_o,
  input  wire logic                         oscillator_clock,
  input  wire logic                         comparator_in,
  input  wire logic                         stop_mode,
  output logic [7:0]                        port_b_select,
  output logic [6:0]                        port_d_select,
  output logic                              high_reference_select,
  output logic                              low_reference_select,
  output logic                              converter_power_on,
  output logic [7:0]                        trial_code,
  output logic                              done_irq
);
  import adc_ctrl_pkg::*;

  typedef struct packed {
    logic                ack;
    logic [DATA_W-1:0]   rdata;
    logic                conversion_done_flag;
    logic                done_interrupt_enable;
    logic                continuous_convert;
    logic [CHAN_W-1:0]   channel_select;
    logic [PRESCALE_W-1:0] clock_prescale;
    logic                input_clock_source;
    logic [7:0]          result;
    logic                irq;
    logic [3:0]          div_cnt;
    logic                osc_s1;
    logic                osc_s2;
    logic                osc_s3;
    logic                cmp_s1;
    logic                cmp_s2;
    conv_state_e         state;
  } ctrl_s;

  ctrl_s r, r_nxt;

  logic       core_busy;
  logic       core_done;
  logic [7:0] core_result;
  logic       src_tick;
  logic       conv_tick;
  logic       div_wrap;
  logic       begin_conv;
  logic       abort_conv;
  logic       bus_req;
  logic       bus_hit;
  logic       wr_status;
  logic       wr_clock;
  logic       rd_result;

  function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    reg_addr = {idx[5:0], 2'b00};
  endfunction

  // Divide ratio minus one
  function automatic logic [3:0] prescale_limit(input logic [2:0] code);
    if (code[2]) begin
      prescale_limit = 4'hF;
    end else begin
      case (code[1:0])
        2'b00:   prescale_limit = 4'h0;
        2'b01:   prescale_limit = 4'h1;
        2'b10:   prescale_limit = 4'h3;
        default: prescale_limit = 4'h7;
      endcase
    end
  endfunction

  function automatic logic [7:0] status_value(input ctrl_s s);
    status_value = {s.conversion_done_flag, s.done_interrupt_enable,
                    s.continuous_convert, s.channel_select};
  endfunction

  assign bus_req   = wb_cyc_i && wb_stb_i && !r.ack;
  // Effects land on the edge where the master samples ack
  assign bus_hit   = wb_cyc_i && wb_stb_i && r.ack;
  assign wr_status = bus_hit && wb_we_i && wb_sel_i[0] &&
                     wb_adr_i == reg_addr(ADC_STATUS_CONTROL_IDX);
  assign wr_clock  = bus_hit && wb_we_i && wb_sel_i[0] &&
                     wb_adr_i == reg_addr(ADC_CLOCK_SELECT_IDX);
  assign rd_result = bus_hit && !wb_we_i && wb_adr_i == reg_addr(ADC_RESULT_IDX);

  // Oscillator edges are counted only after two synchroniser stages
  assign src_tick  = r.input_clock_source ? 1'b1 : (r.osc_s2 && !r.osc_s3);
  // Wrapping at or past the limit keeps ticks coming after a smaller ratio is written
  assign div_wrap  = (r.div_cnt >= prescale_limit(r.clock_prescale));
  assign conv_tick = src_tick && div_wrap;

  assign abort_conv = wr_status || stop_mode;
  assign begin_conv = (r.state == ST_ARMED) && conv_tick && !stop_mode && !wr_status;

  always_comb begin
    r_nxt = r;
    r_nxt.osc_s1 = oscillator_clock;
    r_nxt.osc_s2 = r.osc_s1;
    r_nxt.osc_s3 = r.osc_s2;
    r_nxt.cmp_s1 = comparator_in;
    r_nxt.cmp_s2 = r.cmp_s1;
    r_nxt.ack    = bus_req;

    if (bus_req) begin
      case (wb_adr_i)
        reg_addr(ADC_STATUS_CONTROL_IDX): r_nxt.rdata = {24'h000000, status_value(r)};
        reg_addr(ADC_RESULT_IDX):         r_nxt.rdata = {24'h000000, r.result};
        reg_addr(ADC_CLOCK_SELECT_IDX):   r_nxt.rdata = {24'h000000, r.clock_prescale,
                                                         r.input_clock_source, 4'h0};
        default:                          r_nxt.rdata = 32'h00000000;
      endcase
    end

    if (src_tick) begin
      if (div_wrap) begin
        r_nxt.div_cnt = 4'h0;
      end else begin
        r_nxt.div_cnt = r.div_cnt + 4'h1;
      end
    end

    if (wr_clock) begin
      r_nxt.clock_prescale     = wb_dat_i[PRESCALE_LSB +: PRESCALE_W];
      r_nxt.input_clock_source = wb_dat_i[SRC_BIT];
    end

    // Clears first, so a completion in the same cycle wins
    if (wr_status || rd_result) begin
      r_nxt.conversion_done_flag = 1'b0;
      r_nxt.irq                  = 1'b0;
    end

    if (wr_status) begin
      r_nxt.done_interrupt_enable = wb_dat_i[IRQ_EN_BIT];
      r_nxt.continuous_convert    = wb_dat_i[CONT_BIT];
      r_nxt.channel_select        = wb_dat_i[CHAN_LSB +: CHAN_W];
      // Power-off code arms nothing
      if (wb_dat_i[CHAN_LSB +: CHAN_W] == CHAN_POWER_OFF) begin
        r_nxt.state = ST_IDLE;
      end else begin
        r_nxt.state = ST_ARMED;
      end
    end else begin
      case (r.state)
        ST_ARMED: begin
          if (begin_conv) begin
            r_nxt.state = ST_CONVERT;
          end
        end
        ST_CONVERT: begin
          if (stop_mode) begin
            r_nxt.state = ST_ARMED;
          end else if (core_done) begin
            r_nxt.state = r.continuous_convert ? ST_ARMED : ST_IDLE;
          end
        end
        default: r_nxt.state = r.state;
      endcase
    end

    if (core_done) begin
      r_nxt.result = core_result;
      if (r.done_interrupt_enable) begin
        r_nxt.irq = 1'b1;
      end else begin
        r_nxt.conversion_done_flag = 1'b1;
      end
    end

    if (rst) begin
      r_nxt.ack                   = 1'b0;
      r_nxt.rdata                 = 32'h00000000;
      r_nxt.conversion_done_flag  = 1'b0;
      r_nxt.done_interrupt_enable = 1'b0;
      r_nxt.continuous_convert    = 1'b0;
      r_nxt.channel_select        = CHAN_RESET;
      r_nxt.clock_prescale        = PRESCALE_RESET;
      r_nxt.input_clock_source    = SRC_RESET;
      r_nxt.irq                   = 1'b0;
      r_nxt.div_cnt               = 4'h0;
      r_nxt.osc_s1                = 1'b0;
      r_nxt.osc_s2                = 1'b0;
      r_nxt.osc_s3                = 1'b0;
      r_nxt.cmp_s1                = 1'b0;
      r_nxt.cmp_s2                = 1'b0;
      r_nxt.state                 = ST_IDLE;
      r_nxt.result                = r.result;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || ce) begin
      r <= r_nxt;
    end
  end

  adc_sar_core u_sar (
    .clk        (clk),
    .rst        (rst),
    .ce         (ce),
    .conv_tick  (conv_tick),
    .begin_conv (begin_conv),
    .abort      (abort_conv),
    .comparator (r.cmp_s2),
    .busy       (core_busy),
    .done       (core_done),
    .result     (core_result),
    .trial_code (trial_code)
  );

  // Codes 0F-1C select nothing; their conversions are meaningless
  always_comb begin
    port_b_select = 8'h00;
    port_d_select = 7'h00;
    if (r.channel_select <= CHAN_PORT_B_LAST) begin
      port_b_select[r.channel_select[2:0]] = 1'b1;
    end else if (r.channel_select <= CHAN_PORT_D_LAST) begin
      port_d_select[r.channel_select[2:0]] = 1'b1;
    end
  end

  assign high_reference_select = (r.channel_select == CHAN_REF_HIGH);
  assign low_reference_select  = (r.channel_select == CHAN_REF_LOW);
  assign converter_power_on    = (r.channel_select != CHAN_POWER_OFF);
  assign done_irq              = r.irq;
  assign wb_ack_o              = r.ack;
  assign wb_dat_o              = r.rdata;

  a_flag_on_done : assert property (
    @(posedge clk) disable iff (rst)
    (ce && core_done && !r.done_interrupt_enable) |=> r.conversion_done_flag)
    else $error("done flag missed a completion");

  a_flag_clear : assert property (
    @(posedge clk) disable iff (rst)
    (ce && (wr_status || rd_result) && !core_done) |=> !r.conversion_done_flag && !done_irq)
    else $error("flag or interrupt survived a clearing access");

  a_flag_quiet_ien : assert property (
    @(posedge clk) disable iff (rst)
    (ce && r.done_interrupt_enable && !r.conversion_done_flag && !wr_status)
    |=> !r.conversion_done_flag)
    else $error("done flag set while interrupts enabled");

  a_irq_on_done : assert property (
    @(posedge clk) disable iff (rst)
    (ce && core_done && r.done_interrupt_enable) |=> done_irq)
    else $error("interrupt not raised on completion");

  a_single_idle : assert property (
    @(posedge clk) disable iff (rst)
    (ce && core_done && !r.continuous_convert && !wr_status && !stop_mode)
    |=> (r.state == ST_IDLE) ##1 !core_busy)
    else $error("single conversion did not go idle");

  a_reset_values : assert property (
    @(posedge clk)
    rst |=> (r.channel_select == CHAN_RESET && !r.conversion_done_flag &&
             !r.done_interrupt_enable && !r.continuous_convert && !done_irq))
    else $error("wrong values after reset");

  a_src_reset : assert property (
    @(posedge clk)
    rst |=> (!r.input_clock_source && r.clock_prescale == PRESCALE_RESET))
    else $error("clock source not oscillator after reset");

  a_power_off : assert property (
    @(posedge clk) disable iff (rst)
    (r.channel_select == CHAN_POWER_OFF) |-> (!converter_power_on &&
      port_b_select == 8'h00 && port_d_select == 7'h00))
    else $error("converter powered in power-off code");

  a_result_store : assert property (
    @(posedge clk) disable iff (rst)
    (ce && core_done) |=> (r.result == $past(core_result)))
    else $error("result not stored on completion");

  a_stop_abort : assert property (
    @(posedge clk) disable iff (rst)
    (ce && stop_mode && r.state == ST_CONVERT) |=> (r.state == ST_ARMED && !core_busy))
    else $error("stop did not abort the conversion");

  a_begin_on_tick : assert property (
    @(posedge clk) disable iff (rst)
    (ce && r.state == ST_ARMED && conv_tick && !stop_mode && !wr_status)
    |=> (r.state == ST_CONVERT && core_busy))
    else $error("armed conversion did not start on its tick");

  a_cont_rearm : assert property (
    @(posedge clk) disable iff (rst)
    (ce && core_done && r.continuous_convert && !wr_status && !stop_mode)
    |=> (r.state == ST_ARMED))
    else $error("continuous mode did not rearm");

  a_chan_onehot : assert property (
    @(posedge clk) disable iff (rst)
    $onehot0({port_b_select, port_d_select, high_reference_select, low_reference_select}))
    else $error("more than one analog input selected");

  a_irq_quiet_off : assert property (
    @(posedge clk) disable iff (rst)
    (ce && !r.done_interrupt_enable && !done_irq) |=> !done_irq)
    else $error("interrupt raised while disabled");

  a_prescale_write : assert property (
    @(posedge clk) disable iff (rst)
    (ce && wr_clock) |=> (r.clock_prescale == $past(wb_dat_i[PRESCALE_LSB +: PRESCALE_W]) &&
      r.input_clock_source == $past(wb_dat_i[SRC_BIT])))
    else $error("clock select write not stored");

endmodule // adc_control_registers
`default_nettype wire

// ---- sim/adc_analog_model.sv ----
// Analog side model: one fixed level per channel, compared against the trial code.
// Assumes one-hot channel selects from the converter control block.
`timescale 1ns/1ps
`default_nettype none
module adc_analog_model (
  input  wire logic [7:0] port_b_select,
  input  wire logic [6:0] port_d_select,
  input  wire logic       high_reference_select,
  input  wire logic       low_reference_select,
  input  wire logic       converter_power_on,
  input  wire logic [7:0] trial_code,
  input  wire logic [7:0] level_offset,
  output logic            comparator_in
);
  logic [7:0] vin;
  always_comb begin
    vin = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (port_b_select[i]) vin = 8'h13 + 8'(i) * 8'h11 + level_offset;
    end
    for (int i = 0; i < 7; i++) begin
      if (port_d_select[i]) vin = 8'h9A + 8'(i) * 8'h0B + level_offset;
    end
    if (high_reference_select) vin = 8'hFF;
    if (low_reference_select) vin = 8'h00;
  end
  // A powered-off comparator gives junk, so it follows a changing bit
  assign comparator_in = converter_power_on ? (vin >= trial_code) : trial_code[0];
endmodule // adc_analog_model
`default_nettype wire

// ---- sim/adc_control_registers_tb_top.sv ----
// Register-level testbench of the converter control block.
// Assumes the analog model on the far side and a bus clock of 125 MHz.
`timescale 1ns/1ps
`default_nettype none
module adc_control_registers_tb_top;
  import adc_ctrl_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic        stop = 1'b0;
  logic        ce = 1'b1;
  logic        osc = 1'b0;
  logic [2:0]  osc_cnt = 3'h0;
  logic [7:0]  off = 8'h00;
  logic [31:0] q, dat_o;
  logic        ack, cmp, irq, hi, lo, pwr;
  logic [7:0]  pb, trial;
  logic [6:0]  pd;
  int          errors = 0;
  int          total_checks = 0;
  int          n, div;
  logic [4:0]  ch;

  always #4 clk = ~clk;
  // Oscillator at a tenth of the bus clock
  always @(posedge clk) begin
    osc_cnt <= (osc_cnt == 3'h4) ? 3'h0 : osc_cnt + 3'h1;
    if (osc_cnt == 3'h4) osc <= ~osc;
  end

  adc_control_registers dut (.clk(clk), .rst(rst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .oscillator_clock(osc), .comparator_in(cmp), .stop_mode(stop),
    .port_b_select(pb), .port_d_select(pd), .high_reference_select(hi),
    .low_reference_select(lo), .converter_power_on(pwr), .trial_code(trial), .done_irq(irq));

  adc_analog_model model (.port_b_select(pb), .port_d_select(pd), .high_reference_select(hi),
    .low_reference_select(lo), .converter_power_on(pwr), .trial_code(trial),
    .level_offset(off), .comparator_in(cmp));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task finish_test;
    if (errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wait_flag;
    int k = 0;
    q = 32'h0;
    while (q[7] !== 1'b1 && k < 200) begin
      bus(1'b0, 8'hE0, 8'h00);
      k++;
    end
    check(q[7], 1'b1);
  endtask

  task automatic wait_irq;
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000) errors++;
  endtask

  function automatic logic [7:0] exp_val(input logic [4:0] c, input logic [7:0] o);
    if (c < 5'h08) return 8'h13 + 8'(c) * 8'h11 + o;
    if (c < 5'h0F) return 8'h9A + 8'(c - 5'h08) * 8'h0B + o;
    return (c == 5'h1D) ? 8'hFF : 8'h00;
  endfunction

  function automatic logic [17:0] sel_exp(input logic [4:0] c);
    logic [7:0] b;
    logic [6:0] d;
    b = (c < 5'h08) ? 8'h01 << c : 8'h00;
    d = (c >= 5'h08 && c < 5'h0F) ? 7'h01 << (c - 5'h08) : 7'h00;
    return {b, d, c == 5'h1D, c == 5'h1E, c != 5'h1F};
  endfunction

  initial begin
    #200000;
    errors++;
    finish_test;
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, 8'hE0, 8'h00); check(q, 32'h1F);
    bus(1'b0, 8'hE8, 8'h00); check(q, 32'h00);
    check({pb, pd, hi, lo, pwr}, sel_exp(5'h1F));
    bus(1'b0, 8'hF0, 8'h00); check(q, 32'h00);
    bus(1'b1, 8'hE8, 8'hFF); bus(1'b0, 8'hE8, 8'h00); check(q, 32'hF0);
    bus(1'b1, 8'hE8, 8'h50);
    // First result after power-off is thrown away while the analog side settles
    bus(1'b1, 8'hE0, 8'h00); wait_flag;
    for (int k = 0; k < 17; k++) begin
      ch = (k < 15) ? 5'(k) : 5'(k + 14);
      bus(1'b1, 8'hE0, {3'h0, ch}); wait_flag;
      check({pb, pd, hi, lo, pwr}, sel_exp(ch));
      bus(1'b0, 8'hE4, 8'h00); check(q, exp_val(ch, 8'h00));
      bus(1'b0, 8'hE0, 8'h00); check(q, {27'h0, ch});
    end
    bus(1'b1, 8'hE0, 8'h1B); @(posedge clk);
    check({pb, pd, hi, lo, pwr}, sel_exp(5'h1B));
    bus(1'b1, 8'hE0, 8'h03); wait_flag;
    bus(1'b0, 8'hE4, 8'h00);
    off <= 8'h10;
    repeat (200) @(posedge clk);
    bus(1'b0, 8'hE0, 8'h00); check(q, 32'h03);
    bus(1'b0, 8'hE4, 8'h00); check(q, exp_val(5'h03, 8'h00));
    bus(1'b1, 8'hE0, 8'h03); wait_flag;
    bus(1'b1, 8'hE0, 8'h1F); bus(1'b0, 8'hE0, 8'h00); check(q, 32'h1F);
    repeat (200) @(posedge clk);
    bus(1'b0, 8'hE0, 8'h00); check(q, 32'h1F);
    off <= 8'h00;
    bus(1'b1, 8'hE0, 8'h25); wait_flag;
    off <= 8'h10;
    repeat (200) @(posedge clk);
    bus(1'b0, 8'hE4, 8'h00); check(q, exp_val(5'h05, 8'h10));
    wait_flag; check(q, 32'hA5);
    bus(1'b1, 8'hE0, 8'h45);
    repeat (20) @(posedge clk);
    stop <= 1'b1;
    repeat (200) @(posedge clk);
    check(irq, 1'b0);
    stop <= 1'b0;
    wait_irq; check(n < 100, 1'b1);
    bus(1'b0, 8'hE0, 8'h00); check(q, 32'h45);
    bus(1'b0, 8'hE4, 8'h00); check(q, exp_val(5'h05, 8'h10));
    @(posedge clk); check(irq, 1'b0);
    for (int p = 0; p < 8; p++) begin
      div = (p > 3) ? 16 : (1 << p);
      bus(1'b1, 8'hE8, {3'(p), 5'h10});
      bus(1'b1, 8'hE0, 8'h45);
      wait_irq; check(n >= 15 * div && n <= 16 * div + 4, 1'b1);
      bus(1'b0, 8'hE4, 8'h00);
      @(posedge clk); check(irq, 1'b0);
    end
    bus(1'b1, 8'hE8, 8'h00);
    bus(1'b1, 8'hE0, 8'h45);
    wait_irq; check(n >= 148 && n <= 170, 1'b1);
    bus(1'b1, 8'hE0, 8'h45);
    @(posedge clk); check(irq, 1'b0);
    wait_irq;
    bus(1'b0, 8'hE4, 8'h00); check(q, exp_val(5'h05, 8'h10));
    // Frozen clock enable: the armed conversion must make no progress
    bus(1'b1, 8'hE0, 8'h45);
    ce <= 1'b0;
    repeat (300) @(posedge clk);
    check(irq, 1'b0);
    ce <= 1'b1;
    wait_irq; check(n >= 140 && n <= 175, 1'b1);
    bus(1'b0, 8'hE4, 8'h00); check(q, exp_val(5'h05, 8'h10));
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, 8'hE4, 8'h00); check(q, exp_val(5'h05, 8'h10));
    bus(1'b0, 8'hE0, 8'h00); check(q, 32'h1F);
    check(irq, 1'b0);
    check(trial, 8'h00);
    finish_test;
  end
endmodule // adc_control_registers_tb_top
`default_nettype wire
